//--- dv/fap_eraser.sv
/* Eraser model: erase_done lat+1 cycles into a request.
   Assumes erase_req holds until done. */
`timescale 1ns/1ps
module fap_eraser
(
   // Clock and reset
   input sys_clk,
   input rstn,
   // Delay and handshake
   input [3:0] lat,
   input erase_req,
   output reg erase_done
);
   reg [3:0] n;
   wire w = erase_req && !erase_done;
   always @(posedge sys_clk or negedge rstn)
      if (!rstn)
      begin
         n <= 4'h0;
         erase_done <= 1'b0;
      end
      else
      begin
         erase_done <= w && n == lat;
         n <= w && n != lat ? n + 4'h1 : 4'h0;
      end
endmodule // fap_eraser

//--- dv/fap_gate_monitor.sv
/* Port checker for fap_gate.
   Assumes static settings. */
`timescale 1ns/1ps
module fap_mon
(
   // Clock, reset, settings
   input sys_clk,
   input rstn,
   input [7:0] ctrl_code,
   input [119:0] id_code,
   input [31:0] rom_code,
   // Paths
   input dbg_connect,
   input dbg_id_valid,
   input [119:0] dbg_id,
   input dbg_grant,
   input dbg_id_fail,
   input boot_grant,
   input boot_id_fail,
   input par_grant,
   input erase_req,
   input erase_done,
   input [1:0] policy
);
   wire o = ctrl_code == 8'hff && &id_code && rom_code > 32'h1;
   wire t = ctrl_code != 8'h45 && ctrl_code != 8'h52 && rom_code == 32'h0;
   wire a = dbg_connect && dbg_id_valid && !dbg_grant && t && ctrl_code != 8'hff;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   property p_po; $past(rstn) && o |-> policy == 2'h0; endproperty
   a_po: assert property (p_po) else $error("pol");
   property p_pt; $past(rstn) && t |-> policy == 2'h1; endproperty
   a_pt: assert property (p_pt) else $error("pol");
   property p_pg; $past(rstn) |-> par_grant == (rom_code > 32'h1); endproperty
   a_pg: assert property (p_pg) else $error("par");
   property p_ok; $past(dbg_connect, 5) && a && dbg_id == id_code |=> dbg_grant; endproperty
   a_ok: assert property (p_ok) else $error("dbg");
   property p_ng; $past(dbg_connect, 5) && a && dbg_id != id_code
      |=> dbg_id_fail && !dbg_grant ##1 !erase_req; endproperty
   a_ng: assert property (p_ng) else $error("fail");
   property p_dc; o && dbg_connect |-> ##[0:8] dbg_grant; endproperty
   a_dc: assert property (p_dc) else $error("open");
   property p_bg; (o || t) && $rose(boot_grant) |-> $past(erase_done); endproperty
   a_bg: assert property (p_bg) else $error("boot");
   property p_eh; erase_req && !erase_done |=> erase_req; endproperty
   a_eh: assert property (p_eh) else $error("erase");
   property p_bf; ctrl_code == 8'h45 && $rose(erase_req) |-> boot_id_fail; endproperty
   a_bf: assert property (p_bf) else $error("auth");
   cover property ($rose(dbg_grant));
   cover property ($rose(boot_grant));
   cover property (dbg_id_fail);
endmodule // fap_mon
bind fap_gate fap_mon fap_mon_i (.*);

//--- dv/testbench.sv
/* Bench for fap_gate.
   Assumes the eraser model. */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) \
   begin err_count++; $display("ERROR %0t mismatch", $time); end end
module testbench;
   reg [7:0] ctrl_code = 8'h0;
   reg [119:0] id_code = 120'h0, dbg_id = 120'h0, boot_id = 120'h0;
   reg [31:0] rom_code = 32'h0;
   reg [3:0] lat = 4'h0;
   reg sys_clk = 0, rstn = 0, boot_connect = 0, boot_id_valid = 0;
   reg dbg_connect = 0, dbg_id_valid = 0, pg = 0, pb = 0;
   wire boot_grant, boot_id_fail, dbg_grant, dbg_id_fail, par_grant, erase_req, erase_done;
   wire [1:0] policy;
   wire [7:0] ev = {4'h0, boot_id_fail, boot_grant & ~pb, dbg_grant & ~pg, dbg_id_fail};
   int err_count = 0, checks_done = 0, i;
   byte q[$];
   fap_gate fap_gate_i (.*);
   fap_eraser fap_eraser_i (.*);
   initial forever #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      #1;
      if (ev != 8'h0)
         `CHK(q.pop_front(), ev)
      pg = dbg_grant;
      pb = boot_grant;
   end
   task wrap_up;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task drain;
      for (i = 0; i < 80 && q.size() > 0; i++)
         @(negedge sys_clk);
      `CHK(q.size(), 0)
      if (q.size() > 0)
         wrap_up;
   endtask
   task run(input [7:0] c, input [119:0] id, input [31:0] r, input p);
      {ctrl_code, id_code, rom_code, rstn, boot_connect, dbg_connect} = {c, id, r, 3'h0};
      lat = 4'($urandom);
      repeat (5) @(negedge sys_clk);
      rstn = 1;
      repeat (2) @(negedge sys_clk);
      `CHK(policy, {1'b0, p})
      `CHK(par_grant, !p)
      dbg_connect = 1;
      if (p)
      begin
         repeat (6) @(negedge sys_clk);
         {dbg_id_valid, dbg_id} = {1'b1, id ^ 120'h1};
         q.push_back(1);
         @(negedge sys_clk);
         dbg_id = id;
         q.push_back(2);
         @(negedge sys_clk);
         dbg_id_valid = 0;
      end
      else
         q.push_back(2);
      drain;
      boot_connect = 1;
      q.push_back(4);
      drain;
   endtask
   task run_auth(input [7:0] c, input [119:0] id, input m);
      {ctrl_code, id_code, rom_code, rstn, boot_connect, dbg_connect} = {c, id, 32'h0, 3'h0};
      repeat (5) @(negedge sys_clk);
      rstn = 1;
      repeat (2) @(negedge sys_clk);
      `CHK(policy, 2'h2)
      `CHK(par_grant, 1'b0)
      boot_connect = 1;
      repeat (6) @(negedge sys_clk);
      if (c == 8'h52)
      begin
         repeat (6) @(negedge sys_clk);
         `CHK({boot_grant, erase_req}, 2'h0)
      end
      else
      begin
         for (i = 0; i < 3; i++)
         begin
            boot_id = (i == 2 && m) ? id : id ^ 120'($urandom | 1);
            boot_id_valid = 1;
            q.push_back((i == 2 && m) ? 4 : 8);
            @(negedge sys_clk);
            boot_id_valid = 0;
            @(negedge sys_clk);
         end
         if (!m)
            q.push_back(4);
         drain;
      end
   endtask
   initial
   begin
      i = $urandom(67774);
      run(8'hff, {120{1'b1}}, $urandom | 32'h2, 0);
      run(8'($urandom % 68), 120'({$urandom, $urandom, $urandom, $urandom}), 32'h0, 1);
      run_auth(8'h45, 120'({$urandom, $urandom, $urandom, $urandom}), 1'b0);
      run_auth(8'h45, 120'({$urandom, $urandom, $urandom, $urandom}), 1'b1);
      run_auth(8'h52, 120'({$urandom, $urandom, $urandom, $urandom}), 1'b0);
      wrap_up;
   end
endmodule // testbench

//--- verilog/fap_gate.v
/*
 Flash access protection gate: decodes stored protection settings and
 rules on boot-mode, debugger and parallel programmer access.
 Assumes settings are stable from reset, access request pins are
 asynchronous levels, and a flash eraser answers erase_req with a
 one-cycle erase_done pulse on sys_clk.

*/
`timescale 1ns/1ps
`include "fap_map.vh"
module fap_gate
(
   // Clock and reset
   input wire sys_clk,
   input wire rstn,
   // Stored protection settings
   input wire [`FAP_CTRL_W-1:0] ctrl_code,
   input wire [`FAP_ID_W-1:0] id_code,
   input wire [`FAP_ROM_W-1:0] rom_code,
   // Boot-mode serial path
   input wire boot_connect,
   input wire boot_id_valid,
   input wire [`FAP_ID_W-1:0] boot_id,
   output reg boot_grant,
   output reg boot_id_fail,
   // Debugger path
   input wire dbg_connect,
   input wire dbg_id_valid,
   input wire [`FAP_ID_W-1:0] dbg_id,
   output reg dbg_grant,
   output reg dbg_id_fail,
   // Parallel programmer path
   output reg par_grant,
   // Flash eraser
   output reg erase_req,
   input wire erase_done,
   // Decoded policy
   output reg [1:0] policy
);
   localparam ST_IDLE = 3'h0;
   localparam ST_AUTH = 3'h1;
   localparam ST_ERASE = 3'h2;
   localparam ST_OPEN = 3'h3;
   localparam ST_DENY = 3'h4;

   reg [2:0] boot_st;
   reg [2:0] next_boot_st;
   reg [1:0] fail_cnt;
   reg boot_lvl_d;
   wire boot_lvl;
   wire dbg_lvl;

   // ID-field decoding for the open settings
   function id_open;
      input [`FAP_CTRL_W-1:0] c;
      input [`FAP_ID_W-1:0] id;
      begin
         id_open = (c == `FAP_CTRL_OPEN) && (id == `FAP_ID_ALL_ONES);
      end
   endfunction

   // Whole-word ID comparison, shared by the boot and debugger paths
   function id_eq;
      input [`FAP_ID_W-1:0] presented;
      input [`FAP_ID_W-1:0] stored;
      begin
         id_eq = (presented == stored);
      end
   endfunction

   wire rom_open = (rom_code != `FAP_ROM_LOCK) && (rom_code != `FAP_ROM_PERMLOCK);
   wire ids_open = id_open(ctrl_code, id_code);
   wire boot_auth = (ctrl_code == `FAP_CTRL_BOOTAUTH);
   wire boot_lock = (ctrl_code == `FAP_CTRL_LOCK);
   wire dbg_free = ids_open;
   wire boot_match = id_eq(boot_id, id_code);
   wire dbg_match = id_eq(dbg_id, id_code);

   fap_sync u_boot_sync
   (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pin(boot_connect),
      .level(boot_lvl)
   );

   fap_sync u_dbg_sync
   (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pin(dbg_connect),
      .level(dbg_lvl)
   );

   // Boot-mode connection sequencer
   always @*
   begin
      next_boot_st = boot_st;
      case (boot_st)
         ST_IDLE:
            if (boot_lvl && !boot_lvl_d)
            begin
               if (boot_auth)
                  next_boot_st = ST_AUTH;
               else if (boot_lock)
                  next_boot_st = ST_DENY;
               else
                  next_boot_st = ST_ERASE;
            end
         ST_AUTH:
            if (!boot_lvl)
               next_boot_st = ST_IDLE;
            else if (boot_id_valid && boot_match)
               next_boot_st = ST_OPEN;
            else if (boot_id_valid && fail_cnt == `FAP_BOOT_FAIL_LIMIT - 2'h1)
               next_boot_st = ST_ERASE;
         ST_ERASE:
            if (erase_done)
               next_boot_st = ST_OPEN;
         ST_OPEN, ST_DENY:
            if (!boot_lvl)
               next_boot_st = ST_IDLE;
         default:
            next_boot_st = ST_IDLE;
      endcase
   end

   // Boot path state, fail count and outputs
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         boot_st <= ST_IDLE;
         boot_lvl_d <= 1'b0;
         fail_cnt <= 2'h0;
         boot_grant <= 1'b0;
         boot_id_fail <= 1'b0;
         erase_req <= 1'b0;
      end
      else
      begin
         boot_st <= next_boot_st;
         boot_lvl_d <= boot_lvl;
         boot_grant <= (next_boot_st == ST_OPEN);
         // Erase held until the eraser reports completion
         erase_req <= (next_boot_st == ST_ERASE);
         // Each mismatching boot ID gives a one-cycle fail pulse
         boot_id_fail <= 1'b0;
         if (boot_st == ST_AUTH && boot_lvl && boot_id_valid && !boot_match)
            boot_id_fail <= 1'b1;
         if (boot_st == ST_IDLE)
            fail_cnt <= 2'h0;
         else if (boot_st == ST_AUTH && boot_id_valid)
            fail_cnt <= boot_match ? 2'h0 : fail_cnt + 2'h1;
      end
   end

   // Debugger path: free, or authenticated, dropped on disconnect
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dbg_grant <= 1'b0;
         dbg_id_fail <= 1'b0;
      end
      else
      begin
         dbg_id_fail <= 1'b0;
         if (!dbg_lvl)
            dbg_grant <= 1'b0;
         else if (dbg_free)
            dbg_grant <= 1'b1;
         else if (dbg_id_valid && !dbg_grant)
         begin
            dbg_grant <= dbg_match;
            dbg_id_fail <= !dbg_match;
         end
      end
   end

   // Parallel programmer follows the ROM code only
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         par_grant <= 1'b0;
      end
      else
      begin
         par_grant <= rom_open;
      end
   end

   // Policy report follows the settings only
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         policy <= `FAP_POL_OTHER;
      end
      else
      begin
         if (ids_open && rom_open)
            policy <= `FAP_POL_OPEN;
         else if (!boot_auth && !boot_lock && rom_code == `FAP_ROM_LOCK)
            policy <= `FAP_POL_DBGAUTH;
         else
            policy <= `FAP_POL_OTHER;
      end
   end
endmodule // fap_gate

//--- verilog/fap_map.vh
/*
 Constants for the flash access protection block: setting field widths,
 control and ROM code values, policy encodings and the boot ID fail limit.
 Assumes inclusion by bare name from design files.
*/
`ifndef FAP_MAP_VH
`define FAP_MAP_VH
`define FAP_CTRL_W 8
`define FAP_ID_BYTES 15
`define FAP_ID_W 120
`define FAP_ROM_W 32
`define FAP_CTRL_OPEN 8'hff
`define FAP_CTRL_BOOTAUTH 8'h45
`define FAP_CTRL_LOCK 8'h52
`define FAP_ROM_LOCK 32'h00000000
`define FAP_ROM_PERMLOCK 32'h00000001
`define FAP_ID_ALL_ONES 120'hffffffffffffffffffffffffffffff
`define FAP_BOOT_FAIL_LIMIT 2'h3
`define FAP_POL_OPEN 2'h0
`define FAP_POL_DBGAUTH 2'h1
`define FAP_POL_OTHER 2'h2
`endif

//--- verilog/fap_sync.v
/*
 Three-stage synchroniser with agreement filter for one pin input.
 Assumes the pin is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module fap_sync
(
   // Clock and reset
   input wire sys_clk,
   input wire rstn,
   // Pin and filtered level
   input wire pin,
   output reg level
);
   reg stage1;
   reg stage2;
   reg stage3;

   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         level <= 1'b0;
      end
      else
      begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
         // Change counts once stages two and three agree
         if (stage2 == stage3)
            level <= stage3;
      end
   end
endmodule // fap_sync
